// ### rws_top.sv
`default_nettype none
// How it works
// - Undervoltage: filtered, reset low, then delay
// - Power-up: reset low until supply good plus delay
// - Reset driven but pin high sets stuck flag
// - Clamp monitored only in Normal, Stop, Restart
// - Watchdog reset clamp needs undervolt flag clear
// - Undervolt reset clamp checked once supply recovered
// - Soft reset in Normal/Stop: Init, defaults, no pulse
// - Type select: time-out default, or window
// - Watchdog settings change only in Normal mode
// - Long open window after reset, failure or re-enable
// - Valid watchdog write on chip-select rise triggers
// - Seven periods 10..1000 ms, 200 ms default
// - Failure: Restart, reset low, failure bits set
// - Development mode: watchdog off, no watchdog resets
// - Reset limit stops resets after three failures
// - Time-out mode: trigger anytime, miss means reset
// - Window mode: 60% closed, early trigger resets
// - Odd parity watchdog write ignored, error flag set
// - Stop disable needs fail-safe input disabled, two bits
// - Bad disable sequence clears second bit
// - Re-enable: long open window, both bits cleared
module rws_top #(
    parameter int RF_CYCLES = rws_pkg::RF_CYC,
    parameter int RD_CYCLES = rws_pkg::RD_CYC,
    parameter int MS_CYCLES = rws_pkg::MS_CYC,
    parameter int LW_MS_P = rws_pkg::LW_MS
) (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic SPI_SCK,
    input wire logic SPI_CHIP_SELECT_N,
    input wire logic SPI_MOSI,
    input wire logic MAIN_REGULATOR_UNDERVOLT,
    input wire logic RESET_OUT_N_I,
    output logic RESET_OUT_N_O,
    output logic RESET_OUT_N_OE_N,
    input wire logic DEV_MODE_IN,
    input wire logic FAILSAFE_REQ,
    input wire logic WAKE_REQ,
    output rws_pkg::rws_mode_t MODE_STATE,
    output logic MAIN_SUPPLY_UNDERVOLT_FLAG,
    output logic RESET_PIN_STUCK_HIGH_FLAG,
    output logic [1:0] WDOG_FAILURE_BITS,
    output logic SPI_ERROR_FLAG,
    output logic WDOG_TYPE_SELECT,
    output logic [2:0] WDOG_PERIOD_FIELD,
    output logic STOP_DISABLE_FIRST,
    output logic STOP_DISABLE_SECOND,
    output logic FAILSAFE_INPUT_DISABLE,
    output logic WDOG_LONG_WINDOW
);
    import rws_pkg::*;

    if (RF_CYCLES < 1 || RD_CYCLES < 1 || MS_CYCLES < 1 || LW_MS_P < 1 || LW_MS_P > 65535)
    begin : g_bad_param
        $error("rws_top: timing parameter out of range");
    end

    // ----------------------------------------------------------------
    // Link side, clocked by the serial clock
    // ----------------------------------------------------------------
    // Chip select high clears the bit count, since the serial clock
    // stands still between frames.
    logic [4:0] bit_cnt_q = 5'h00;
    logic [14:0] sh_q;
    logic [15:0] word_q;
    logic tgl_q = 1'b0;

    always_ff @(posedge SPI_SCK or posedge SPI_CHIP_SELECT_N) begin
        if (SPI_CHIP_SELECT_N) begin
            bit_cnt_q <= 5'h00;
        end else if (bit_cnt_q != 5'h10) begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
        end
    end

    always_ff @(posedge SPI_SCK) begin
        sh_q <= {sh_q[13:0], SPI_MOSI};
        if (!SPI_CHIP_SELECT_N && bit_cnt_q == 5'h0F) begin
            word_q <= {sh_q, SPI_MOSI};
            tgl_q <= ~tgl_q;
        end
    end

    // ----------------------------------------------------------------
    // Synchronisers into the main clock
    // ----------------------------------------------------------------
    logic [6:0] sync1_q;
    logic [6:0] sync2_q;
    logic csn_s3_q;
    logic seen_q;

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            sync1_q <= SYNC_RST;
            sync2_q <= SYNC_RST;
            csn_s3_q <= 1'b1;
        end else begin
            sync1_q <= {SPI_CHIP_SELECT_N, tgl_q, MAIN_REGULATOR_UNDERVOLT, RESET_OUT_N_I,
                        DEV_MODE_IN, FAILSAFE_REQ, WAKE_REQ};
            sync2_q <= sync1_q;
            csn_s3_q <= sync2_q[SI_CSN];
        end
    end

    // The frame word is stable while chip select is high, so the
    // toggle acts as the handshake for it.
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            seen_q <= sync2_q[SI_TGL];
        end else if (sync2_q[SI_CSN] && !csn_s3_q) begin
            seen_q <= sync2_q[SI_TGL];
        end
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    rws_mode_t mode_q;
    logic ro_rel_q, cause_wd_q, uv_det_q, ro_o_q;
    logic [31:0] rd_cnt_q, rf_cnt_q, pre_q;
    logic [2:0] ro_low_cnt_q;
    logic [15:0] wd_ms_q;
    logic wd_lw_q;
    logic win_q, limit_q, first_q, second_q, fsi_q;
    logic [2:0] period_q;
    logic uv_flag_q, stuck_q, spi_err_q;
    logic [1:0] fail_cnt_q;

    logic uv_s, ro_in_s, dev_s, fs_s, wake_s;
    logic csn_rise, frm_ok, wr_ev, wdc_wr, par_bad, spi_bad, mode_wr, soft_rst;
    logic [6:0] addr;
    logic [7:0] data;
    logic reg_on, wd_dis, wd_on, closed_hit, timeout, wdog_failure_bits, wd_accept, wd_reset_go;
    logic stop_wake, stop_to_norm, uv_evt, rel_evt, clamp_cond;
    logic [15:0] per16, closed_ms, limit_ms;

    always_comb begin
        uv_s = sync2_q[SI_UV];
        ro_in_s = sync2_q[SI_RO];
        dev_s = sync2_q[SI_DEV];
        fs_s = sync2_q[SI_FS];
        wake_s = sync2_q[SI_WAKE];
        csn_rise = sync2_q[SI_CSN] && !csn_s3_q;
        frm_ok = csn_rise && (sync2_q[SI_TGL] != seen_q);
        addr = word_q[FRM_ADDR_MSB:0];
        data = word_q[15:FRM_DATA_LSB];
        wr_ev = frm_ok && word_q[FRM_WR];
        wdc_wr = wr_ev && addr == A_WDOG && ~^data;
        par_bad = wr_ev && addr == A_WDOG && ^data;
        spi_bad = par_bad || (csn_rise && !frm_ok);
        mode_wr = wr_ev && addr == A_MODE;
        soft_rst = mode_wr && data[1:0] == MC_SOFT
                   && (mode_q == M_NORMAL || mode_q == M_STOP);
        reg_on = mode_q != M_SLEEP && mode_q != M_FAILSAFE;
        wd_dis = first_q && second_q;
        // Watchdog runs only after reset release and never in
        // development mode.
        wd_on = ro_rel_q && !dev_s && (mode_q == M_INIT || mode_q == M_NORMAL
                || (mode_q == M_STOP && !wd_dis));
        per16 = {6'h00, rws_per_ms(period_q)};
        closed_ms = 16'((32'(per16) * CLOSED_PCT) / 100);
        limit_ms = wd_lw_q ? 16'(LW_MS_P) : per16;
        closed_hit = wdc_wr && wd_on && win_q && !wd_lw_q && wd_ms_q < closed_ms;
        timeout = wd_on && wd_ms_q >= limit_ms;
        wdog_failure_bits = closed_hit || timeout;
        wd_accept = wdc_wr && wd_on && !closed_hit;
        wd_reset_go = wdog_failure_bits && !(limit_q && fail_cnt_q == FAIL_MAX);
        stop_wake = wdc_wr && mode_q == M_STOP && wd_dis;
        stop_to_norm = mode_wr && mode_q == M_STOP && data[1:0] == MC_NORMAL;
        uv_evt = reg_on && uv_s && !uv_det_q && rf_cnt_q == 32'(RF_CYCLES - 1);
        rel_evt = reg_on && !ro_rel_q && !uv_s && rd_cnt_q == 32'(RD_CYCLES - 1);
        // Feedback is trusted only after the drive has had time to
        // pass the synchroniser, else a clean pin would look clamped.
        clamp_cond = !ro_rel_q && ro_low_cnt_q == CLAMP_SETTLE && ro_in_s
                     && (mode_q == M_NORMAL || mode_q == M_STOP
                         || mode_q == M_RESTART)
                     && (cause_wd_q ? !uv_flag_q : !uv_s);
    end

    // ----------------------------------------------------------------
    // Operating mode
    // ----------------------------------------------------------------
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            mode_q <= M_INIT;
        end else if (fs_s && mode_q != M_FAILSAFE) begin
            mode_q <= M_FAILSAFE;
        end else if (uv_evt && mode_q != M_INIT) begin
            mode_q <= M_RESTART;
        end else if (wd_reset_go) begin
            mode_q <= M_RESTART;
        end else if (soft_rst) begin
            mode_q <= M_INIT;
        end else begin
            case (mode_q)
                M_INIT, M_NORMAL: begin
                    if (mode_wr && data[1:0] == MC_NORMAL) begin
                        mode_q <= M_NORMAL;
                    end else if (mode_wr && data[1:0] == MC_STOP) begin
                        mode_q <= M_STOP;
                    end else if (mode_wr && data[1:0] == MC_SLEEP) begin
                        mode_q <= M_SLEEP;
                    end
                end
                M_STOP: begin
                    if (stop_to_norm) begin
                        mode_q <= M_NORMAL;
                    end
                end
                M_RESTART: begin
                    if (rel_evt) begin
                        mode_q <= M_NORMAL;
                    end
                end
                M_SLEEP: begin
                    if (wake_s) begin
                        mode_q <= M_RESTART;
                    end
                end
                default: begin
                    if (wake_s && !fs_s) begin
                        mode_q <= M_RESTART;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Reset output engine
    // ----------------------------------------------------------------
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            ro_rel_q <= 1'b0;
            rd_cnt_q <= 32'h0;
            cause_wd_q <= 1'b0;
        end else if (!reg_on) begin
            ro_rel_q <= 1'b0;
            rd_cnt_q <= 32'h0;
        end else if (uv_evt) begin
            ro_rel_q <= 1'b0;
            rd_cnt_q <= 32'h0;
            cause_wd_q <= 1'b0;
        end else if (wd_reset_go) begin
            ro_rel_q <= 1'b0;
            rd_cnt_q <= 32'h0;
            cause_wd_q <= 1'b1;
        end else if (!ro_rel_q) begin
            if (uv_s) begin
                rd_cnt_q <= 32'h0;
            end else if (rel_evt) begin
                ro_rel_q <= 1'b1;
            end else begin
                rd_cnt_q <= rd_cnt_q + 32'h1;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N || ro_rel_q) begin
            ro_low_cnt_q <= 3'h0;
        end else if (ro_low_cnt_q != CLAMP_SETTLE) begin
            ro_low_cnt_q <= ro_low_cnt_q + 3'h1;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N || !uv_s) begin
            rf_cnt_q <= 32'h0;
            uv_det_q <= 1'b0;
        end else if (rf_cnt_q != 32'(RF_CYCLES - 1)) begin
            rf_cnt_q <= rf_cnt_q + 32'h1;
        end else begin
            uv_det_q <= 1'b1;
        end
    end

    // Pin level is always low; only the enable moves.
    always_ff @(posedge MCLK) begin
        ro_o_q <= 1'b0;
    end

    // ----------------------------------------------------------------
    // Watchdog timer
    // ----------------------------------------------------------------
    // Counting whole milliseconds keeps the period counter narrow.
    always_ff @(posedge MCLK) begin
        if (!RST_N || soft_rst || !wd_on) begin
            wd_ms_q <= 16'h0000;
            pre_q <= 32'h0;
            wd_lw_q <= 1'b1;
        end else if (wd_accept) begin
            wd_ms_q <= 16'h0000;
            pre_q <= 32'h0;
            wd_lw_q <= 1'b0;
        end else if (wdog_failure_bits) begin
            wd_ms_q <= 16'h0000;
            pre_q <= 32'h0;
            wd_lw_q <= 1'b1;
        end else if (pre_q == 32'(MS_CYCLES - 1)) begin
            pre_q <= 32'h0;
            wd_ms_q <= wd_ms_q + 16'h0001;
        end else begin
            pre_q <= pre_q + 32'h1;
        end
    end

    // ----------------------------------------------------------------
    // Watchdog configuration
    // ----------------------------------------------------------------
    always_ff @(posedge MCLK) begin
        if (!RST_N || soft_rst) begin
            win_q <= 1'b0;
            limit_q <= 1'b0;
            period_q <= PER_RST;
            first_q <= 1'b0;
            second_q <= 1'b0;
            fsi_q <= 1'b0;
        end else begin
            if (mode_q == M_NORMAL && wdc_wr) begin
                win_q <= data[WDC_TYPE];
                limit_q <= data[WDC_LIMIT];
                period_q <= data[WDC_PER_MSB:0];
                first_q <= data[WDC_STOP_DIS];
            end
            if (mode_q == M_NORMAL && wr_ev && addr == A_HW) begin
                fsi_q <= data[HW_FSI_DIS];
            end
            if (mode_q == M_NORMAL && wr_ev && addr == A_WAKE) begin
                second_q <= data[WK_STOP_DIS] && first_q && fsi_q;
            end
            if (stop_wake || stop_to_norm) begin
                first_q <= 1'b0;
                second_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Status flags; a set in the clearing cycle wins
    // ----------------------------------------------------------------
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            uv_flag_q <= 1'b0;
            stuck_q <= 1'b0;
            spi_err_q <= 1'b0;
        end else begin
            uv_flag_q <= uv_evt || (uv_flag_q && !soft_rst
                         && !(wr_ev && addr == A_SUP && data[SUP_UV_CLR]));
            stuck_q <= clamp_cond || (stuck_q && !soft_rst
                       && !(wr_ev && addr == A_DEV && data[DEV_CLAMP_CLR]));
            spi_err_q <= spi_bad || (spi_err_q && !soft_rst
                         && !(wr_ev && addr == A_DEV && data[DEV_SPI_CLR]));
        end
    end

    // Counts consecutive failures; a good trigger restarts the run.
    always_ff @(posedge MCLK) begin
        if (!RST_N || soft_rst) begin
            fail_cnt_q <= 2'h0;
        end else if (wdog_failure_bits && fail_cnt_q != FAIL_MAX) begin
            fail_cnt_q <= fail_cnt_q + 2'h1;
        end else if (wd_accept) begin
            fail_cnt_q <= 2'h0;
        end
    end

    assign MODE_STATE = mode_q;
    assign RESET_OUT_N_O = ro_o_q;
    assign RESET_OUT_N_OE_N = ro_rel_q;
    assign MAIN_SUPPLY_UNDERVOLT_FLAG = uv_flag_q;
    assign RESET_PIN_STUCK_HIGH_FLAG = stuck_q;
    assign WDOG_FAILURE_BITS = fail_cnt_q;
    assign SPI_ERROR_FLAG = spi_err_q;
    assign WDOG_TYPE_SELECT = win_q;
    assign WDOG_PERIOD_FIELD = period_q;
    assign STOP_DISABLE_FIRST = first_q;
    assign STOP_DISABLE_SECOND = second_q;
    assign FAILSAFE_INPUT_DISABLE = fsi_q;
    assign WDOG_LONG_WINDOW = wd_lw_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    sequence s_bad_second;
        mode_q == M_NORMAL && wr_ev && addr == A_WAKE && !(first_q && fsi_q);
    endsequence
    sequence s_stop_reenable;
        stop_wake && !soft_rst;
    endsequence

    AST_UV_LOW: assert property (uv_evt |=> !ro_rel_q)
        else $error("undervoltage did not pull reset low");
    AST_RELEASE: assert property ($rose(ro_rel_q) |-> $past(rd_cnt_q) == 32'(RD_CYCLES - 1))
        else $error("reset released before delay");
    AST_CLAMP: assert property ($rose(stuck_q) |-> $past(!ro_rel_q && ro_in_s))
        else $error("clamp flag without driven reset and high pin");
    AST_CLAMP_MODE: assert property ($rose(stuck_q) |-> $past(reg_on && mode_q != M_INIT))
        else $error("clamp flagged in unmonitored mode");
    AST_CLAMP_WD: assert property ($rose(stuck_q) && $past(cause_wd_q) |-> !$past(uv_flag_q))
        else $error("watchdog clamp flagged with undervolt flag set");
    AST_SOFT: assert property (soft_rst |=> mode_q == M_INIT && ro_rel_q == $past(ro_rel_q))
        else $error("soft reset wrong");
    AST_CFG_STOP: assert property (mode_q == M_STOP && !soft_rst
                                   |=> $stable(period_q) && $stable(win_q))
        else $error("watchdog setting changed in stop mode");
    AST_WDOG_FAILURE_BITS: assert property (wd_reset_go |=> mode_q == M_RESTART && !ro_rel_q)
        else $error("watchdog failure without restart");
    AST_DEV: assert property (dev_s |=> wd_ms_q == 16'h0000 && wd_lw_q)
        else $error("watchdog runs in development mode");
    AST_LIMIT: assert property (wdog_failure_bits && limit_q && fail_cnt_q == FAIL_MAX && !fs_s && !uv_evt
                                |=> $stable(mode_q))
        else $error("reset issued past limit");
    AST_PARITY: assert property (par_bad |=> spi_err_q && $stable(period_q) && $stable(win_q))
        else $error("odd parity write not ignored");
    AST_SEQ_ERR: assert property (s_bad_second |=> !second_q)
        else $error("second disable bit kept after bad sequence");
    AST_REENABLE: assert property (s_stop_reenable |=> !first_q && !second_q ##1 wd_lw_q)
        else $error("stop re-enable did not clear bits");
endmodule
`default_nettype wire

// ### rws_pkg.sv
`default_nettype none
package rws_pkg;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 200;
    localparam int RF_US = 10;
    localparam int RD_US = 10000;
    localparam int MS_US = 1000;
    localparam int LW_MS = 200;
    localparam int RF_CYC = RF_US * CLK_MHZ;
    localparam int RD_CYC = RD_US * CLK_MHZ;
    localparam int MS_CYC = MS_US * CLK_MHZ;
    localparam int CLOSED_PCT = 60;
    // Watchdog periods in ms: 10, 20, 50, 100, 200, 500, 1000
    localparam logic [9:0] PER_MS_1 = 10'h00A;
    localparam logic [9:0] PER_MS_2 = 10'h014;
    localparam logic [9:0] PER_MS_3 = 10'h032;
    localparam logic [9:0] PER_MS_4 = 10'h064;
    localparam logic [9:0] PER_MS_5 = 10'h0C8;
    localparam logic [9:0] PER_MS_6 = 10'h1F4;
    localparam logic [9:0] PER_MS_7 = 10'h3E8;
    localparam logic [2:0] CLAMP_SETTLE = 3'h3;
    localparam logic [1:0] FAIL_MAX = 2'h3;
    // ----------------------------------------------------------------
    // Serial frame and register map
    // ----------------------------------------------------------------
    localparam int FRM_WR = 7;
    localparam int FRM_ADDR_MSB = 6;
    localparam int FRM_DATA_LSB = 8;
    localparam logic [6:0] A_MODE = 7'h01;
    localparam logic [6:0] A_WDOG = 7'h03;
    localparam logic [6:0] A_WAKE = 7'h04;
    localparam logic [6:0] A_HW = 7'h0E;
    localparam logic [6:0] A_SUP = 7'h40;
    localparam logic [6:0] A_DEV = 7'h41;
    localparam int WDC_STOP_DIS = 6;
    localparam int WDC_TYPE = 5;
    localparam int WDC_LIMIT = 4;
    localparam int WDC_PER_MSB = 2;
    localparam int WK_STOP_DIS = 2;
    localparam int HW_FSI_DIS = 0;
    localparam int SUP_UV_CLR = 0;
    localparam int DEV_CLAMP_CLR = 0;
    localparam int DEV_SPI_CLR = 1;
    localparam logic [1:0] MC_NORMAL = 2'h0;
    localparam logic [1:0] MC_SLEEP = 2'h1;
    localparam logic [1:0] MC_STOP = 2'h2;
    localparam logic [1:0] MC_SOFT = 2'h3;
    localparam logic [2:0] PER_RST = 3'h5;
    // ----------------------------------------------------------------
    // Synchroniser vector layout
    // ----------------------------------------------------------------
    localparam int SI_CSN = 6;
    localparam int SI_TGL = 5;
    localparam int SI_UV = 4;
    localparam int SI_RO = 3;
    localparam int SI_DEV = 2;
    localparam int SI_FS = 1;
    localparam int SI_WAKE = 0;
    localparam logic [6:0] SYNC_RST = 7'h40;

    typedef enum logic [2:0] {
        M_INIT = 3'h0,
        M_NORMAL = 3'h1,
        M_STOP = 3'h3,
        M_RESTART = 3'h2,
        M_SLEEP = 3'h6,
        M_FAILSAFE = 3'h4
    } rws_mode_t;

    function automatic logic [9:0] rws_per_ms(input logic [2:0] field);
        case (field)
            3'h1: rws_per_ms = PER_MS_1;
            3'h2: rws_per_ms = PER_MS_2;
            3'h3: rws_per_ms = PER_MS_3;
            3'h4: rws_per_ms = PER_MS_4;
            3'h6: rws_per_ms = PER_MS_6;
            3'h7: rws_per_ms = PER_MS_7;
            default: rws_per_ms = PER_MS_5;
        endcase
    endfunction
endpackage
`default_nettype wire

// ### rws_host.sv
`default_nettype none
module rws_host (
    output logic sck,
    output logic csn_n,
    output logic mosi
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        sck = 1'b0;
        csn_n = 1'b1;
        mosi = 1'b0;
    end
    // ------------------------------------------------------------
    // Frame driver: 160 ns link clock, still outside frames
    // ------------------------------------------------------------
    task automatic send(input logic [15:0] f);
        #1.3 csn_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            mosi = f[i];
            #80 sck = 1'b1;
            #80 sck = 1'b0;
        end
        #80 csn_n = 1'b1;
        // Line not held: show the inverse so stale data cannot pass
        mosi = ~mosi;
        #40;
    endtask
endmodule
`default_nettype wire

// ### rws_top_bench.sv
`default_nettype none
module rws_top_bench;
    import rws_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic uv = 1'b0;
    logic clamp = 1'b0;
    logic dev = 1'b0;
    logic wake = 1'b0;
    logic pin;
    wire sck;
    wire csn_n;
    wire mosi;
    rws_mode_t mode;
    logic ro_o, oe_n, uv_f, stuck, spi_err, wtype, stop1, stop2, fsi_dis, lw;
    logic [1:0] fail;
    logic [2:0] per;
    logic [31:0] seed = 32'h4CFB;
    int n_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    int exp_fail = 0;
    // Pull-up on the reset pin unless driven low, or clamped from outside
    assign pin = clamp | oe_n;
    rws_host u_host (.sck(sck), .csn_n(csn_n), .mosi(mosi));
    rws_top #(.RF_CYCLES(4), .RD_CYCLES(20), .MS_CYCLES(100), .LW_MS_P(40)) u_dut (
        .MCLK(mclk), .RST_N(rst_n), .SPI_SCK(sck), .SPI_CHIP_SELECT_N(csn_n),
        .SPI_MOSI(mosi), .MAIN_REGULATOR_UNDERVOLT(uv), .RESET_OUT_N_I(pin),
        .RESET_OUT_N_O(ro_o), .RESET_OUT_N_OE_N(oe_n), .DEV_MODE_IN(dev),
        .FAILSAFE_REQ(1'b0), .WAKE_REQ(wake), .MODE_STATE(mode),
        .MAIN_SUPPLY_UNDERVOLT_FLAG(uv_f), .RESET_PIN_STUCK_HIGH_FLAG(stuck),
        .WDOG_FAILURE_BITS(fail), .SPI_ERROR_FLAG(spi_err), .WDOG_TYPE_SELECT(wtype),
        .WDOG_PERIOD_FIELD(per), .STOP_DISABLE_FIRST(stop1), .STOP_DISABLE_SECOND(stop2),
        .FAILSAFE_INPUT_DISABLE(fsi_dis), .WDOG_LONG_WINDOW(lw));
    always #2.5 mclk = ~mclk;
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic final_report;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    // Data bit 7 fills the byte to even parity; bad flips it
    task automatic wr(input logic [6:0] a, input logic [6:0] d, input logic bad);
        u_host.send({(^d) ^ bad, d, 1'b1, a});
        repeat (8) @(negedge mclk);
    endtask
    task automatic wait_mode(input rws_mode_t m, input int n);
        int k;
        k = 0;
        while (mode !== m && k < n) begin
            @(negedge mclk);
            k++;
        end
        chk("mode", 8'(m), 8'(mode));
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 60000) begin
            n_errors++;
            final_report();
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [2:0] p;
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
        chk("mode", 8'(M_INIT), 8'(mode));
        chk("per", 8'(PER_RST), 8'(per));
        chk("type", 8'h00, 8'(wtype));
        chk("oe_n", 8'h00, 8'(oe_n));
        repeat (30) @(negedge mclk);
        chk("oe_n", 8'h01, 8'(oe_n));
        chk("lw", 8'h01, 8'(lw));
        wr(A_MODE, 7'h03, 1'b0);
        chk("mode", 8'(M_INIT), 8'(mode));
        wr(A_MODE, 7'h00, 1'b0);
        chk("mode", 8'(M_NORMAL), 8'(mode));
        wr(A_WDOG, 7'h01, 1'b1);
        chk("spi_err", 8'h01, 8'(spi_err));
        chk("per", 8'(PER_RST), 8'(per));
        seed = lfsr(seed);
        p = 3'(seed % 7 + 1);
        wr(A_WDOG, {4'h0, p}, 1'b0);
        chk("per", 8'(p), 8'(per));
        for (int i = 7; i >= 1; i--) begin
            wr(A_WDOG, {4'h0, 3'(i)}, 1'b0);
            chk("per", 8'(i), 8'(per));
        end
        // Time-out mode at 10 ms left unserved
        wait_mode(M_RESTART, 1200);
        exp_fail++;
        chk("oe_n", 8'h00, 8'(oe_n));
        chk("fail", 8'(exp_fail), 8'(fail));
        clamp = 1'b1;
        repeat (10) @(negedge mclk);
        chk("stuck", 8'h01, 8'(stuck));
        clamp = 1'b0;
        wait_mode(M_NORMAL, 100);
        chk("lw", 8'h01, 8'(lw));
        wr(A_WDOG, 7'h22, 1'b0);
        // A good trigger ends the run of consecutive failures
        exp_fail = 0;
        chk("type", 8'h01, 8'(wtype));
        chk("fail", 8'(exp_fail), 8'(fail));
        // Served inside the open part of a 20 ms period
        repeat (1100) @(negedge mclk);
        wr(A_WDOG, 7'h22, 1'b0);
        chk("mode", 8'(M_NORMAL), 8'(mode));
        // Next trigger lands inside the 60 % closed part
        wr(A_WDOG, 7'h22, 1'b0);
        wait_mode(M_RESTART, 50);
        exp_fail++;
        chk("fail", 8'(exp_fail), 8'(fail));
        wait_mode(M_NORMAL, 100);
        wr(A_MODE, 7'h03, 1'b0);
        chk("mode", 8'(M_INIT), 8'(mode));
        chk("oe_n", 8'h01, 8'(oe_n));
        chk("type", 8'h00, 8'(wtype));
        chk("fail", 8'h00, 8'(fail));
        uv = 1'b1;
        repeat (2) @(negedge mclk);
        uv = 1'b0;
        repeat (5) @(negedge mclk);
        chk("oe_n", 8'h01, 8'(oe_n));
        uv = 1'b1;
        repeat (10) @(negedge mclk);
        chk("oe_n", 8'h00, 8'(oe_n));
        chk("uv_f", 8'h01, 8'(uv_f));
        uv = 1'b0;
        repeat (10) @(negedge mclk);
        chk("oe_n", 8'h00, 8'(oe_n));
        repeat (20) @(negedge mclk);
        chk("oe_n", 8'h01, 8'(oe_n));
        chk("ro_o", 8'h00, 8'(ro_o));
        // Long window would expire here if the watchdog ran
        dev = 1'b1;
        repeat (4500) @(negedge mclk);
        chk("mode", 8'(M_INIT), 8'(mode));
        chk("lw", 8'h01, 8'(lw));
        dev = 1'b0;
        wr(A_MODE, 7'h00, 1'b0);
        wr(A_MODE, 7'h01, 1'b0);
        chk("mode", 8'(M_SLEEP), 8'(mode));
        chk("oe_n", 8'h00, 8'(oe_n));
        wake = 1'b1;
        wait_mode(M_RESTART, 10);
        wake = 1'b0;
        wait_mode(M_NORMAL, 50);
        chk("lw", 8'h01, 8'(lw));
        wr(A_HW, 7'h01, 1'b0);
        wr(A_WAKE, 7'h04, 1'b0);
        chk("stop2", 8'h00, 8'(stop2));
        wr(A_WDOG, 7'h45, 1'b0);
        wr(A_WAKE, 7'h04, 1'b0);
        chk("fsi_dis", 8'h01, 8'(fsi_dis));
        chk("stop", 8'h03, 8'({stop1, stop2}));
        wr(A_MODE, 7'h02, 1'b0);
        chk("mode", 8'(M_STOP), 8'(mode));
        wr(A_WDOG, 7'h01, 1'b0);
        chk("stop", 8'h00, 8'({stop1, stop2}));
        chk("lw", 8'h01, 8'(lw));
        chk("per", 8'(PER_RST), 8'(per));
        final_report();
    end
endmodule
`default_nettype wire
